// ---- hdl/sscr_pkg.sv ----
package sscr_pkg;
	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam logic [7:0] ADDR_STATS_CTRL  = 8'h08;
	localparam logic [7:0] ADDR_FACT_TEST_A = 8'h09;
	localparam logic [7:0] ADDR_FACT_TEST_B = 8'h0A;
	localparam logic [7:0] ADDR_EDGE_LED    = 8'h0B;

	localparam logic [7:0] RST_STATS_CTRL  = 8'h00;
	localparam logic [7:0] RST_FACT_TEST_A = 8'h40;
	localparam logic [7:0] RST_FACT_TEST_B = 8'h00;
	localparam logic [7:0] RST_EDGE_LED    = 8'h00;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int BIT_CLEAR      = 7;
	localparam int BIT_HOLD       = 6;
	localparam int BIT_REF_EDGE   = 6;
	localparam int BIT_SPI_EDGE   = 0;
	localparam int BIT_HOST_REFERENCE_CLOCK_OUT = 1;
	localparam int LED_MODE_HI    = 5;
	localparam int LED_MODE_LO    = 4;
	localparam int NUM_PORTS      = 5;

	// counters held per port, and clear walk length
	localparam int                CNT_PER_PORT = 36;
	localparam logic [5:0]        CLR_LAST     = 6'h23;
	localparam logic [5:0]        IDX_FIRST    = 6'h00;
	localparam logic [5:0]        IDX_STEP     = 6'h01;
	localparam logic [NUM_PORTS-1:0] PORTS_NONE = 5'h00;

	typedef enum logic [0:0] {
		SSCR_IDLE  = 1'b0,
		SSCR_CLEAR = 1'b1
	} sscr_state_t;
endpackage

// ---- hdl/sscr_regs.sv ----
`timescale 1ns/100ps
// Operation
// - writing one to the clear bit zeroes every statistics counter of each enabled port.
// - the clear bit drops to zero by itself when the clear walk has finished.
// - while the hold bit is one, counters of enabled ports stop counting.
// - a five-bit enable field, bit 4 for port 5 down to bit 0 for port 1, picks the ports.
// - the reference-clock edge bit picks falling (1) or rising (0) edge on the host port.
// - the serial read-edge bit, zero at reset, picks the serial clock edge for read data.
module sscr_regs (
	// clock and reset
	input  wire logic                              i_ref_clk,
	input  wire logic                              i_resetn,
	// register port
	input  wire logic                              i_wr_en,
	input  wire logic                              i_rd_en,
	input  wire logic [7:0]                        i_addr,
	input  wire logic [7:0]                        i_wdata,
	output logic      [7:0]                        o_rdata,
	output logic                                   o_rvalid,
	// statistics counter control
	output logic      [sscr_pkg::NUM_PORTS-1:0]    o_stats_hold,
	output logic      [sscr_pkg::NUM_PORTS-1:0]    o_stats_clear_port,
	output logic      [5:0]                        o_stats_clear_index,
	output logic                                   o_stats_clear_we,
	// edge selects
	output logic                                   o_ref_clk_falling,
	output logic                                   o_spi_read_rising
);
	import sscr_pkg::*;

	// ----------------------------------------
	// control state
	// ----------------------------------------
	logic                 clear_q;
	logic                 hold_q;
	logic [NUM_PORTS-1:0] port_en_q;
	logic                 ref_edge_q;
	logic                 spi_edge_q;
	logic [1:0]           led_mode_q;
	logic                 host_reference_clock_out_q;
	sscr_state_t          state_q;
	logic [5:0]           idx_q;
	logic [NUM_PORTS-1:0] clr_ports_q;

	// ----------------------------------------
	// decode helpers
	// ----------------------------------------
	// one compare shared by both write decoders
	function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] reg_addr);
		addr_hit = (addr == reg_addr);
	endfunction

	function automatic logic is_walking(input sscr_state_t state);
		is_walking = (state == SSCR_CLEAR);
	endfunction

	// bit 5 is reserved and reads zero
	function automatic logic [7:0] stats_image(input logic clr, input logic hld,
			input logic [NUM_PORTS-1:0] en);
		logic [7:0] img;
		img                = 8'h00;
		img[BIT_CLEAR]     = clr;
		img[BIT_HOLD]      = hld;
		img[NUM_PORTS-1:0] = en;
		stats_image        = img;
	endfunction

	// top bit and bits 3..2 are reserved and read zero
	function automatic logic [7:0] edge_image(input logic ref_edge, input logic [1:0] led,
			input logic host_reference_clock_out, input logic spi_edge);
		logic [7:0] img;
		img                          = 8'h00;
		img[BIT_REF_EDGE]            = ref_edge;
		img[LED_MODE_HI:LED_MODE_LO] = led;
		img[BIT_HOST_REFERENCE_CLOCK_OUT]          = host_reference_clock_out;
		img[BIT_SPI_EDGE]            = spi_edge;
		edge_image                   = img;
	endfunction

	logic wr_stats;
	logic wr_edge;
	logic clear_done;
	assign wr_stats   = i_wr_en && addr_hit(i_addr, ADDR_STATS_CTRL);
	assign wr_edge    = i_wr_en && addr_hit(i_addr, ADDR_EDGE_LED);
	assign clear_done = is_walking(state_q) && (idx_q == CLR_LAST);

	// ----------------------------------------
	// stats control register
	// ----------------------------------------
	always_ff @(posedge i_ref_clk) begin
		if (!i_resetn) begin
			hold_q    <= RST_STATS_CTRL[BIT_HOLD];
			port_en_q <= RST_STATS_CTRL[NUM_PORTS-1:0];
		end else if (wr_stats) begin
			hold_q    <= i_wdata[BIT_HOLD];
			port_en_q <= i_wdata[NUM_PORTS-1:0];
		end
	end

	// a new write of one while busy keeps the bit set; completion clears it
	always_ff @(posedge i_ref_clk) begin
		if (!i_resetn) begin
			clear_q <= RST_STATS_CTRL[BIT_CLEAR];
		end else if (wr_stats && i_wdata[BIT_CLEAR]) begin
			clear_q <= 1'b1;
		end else if (clear_done) begin
			clear_q <= 1'b0;
		end
	end

	// ----------------------------------------
	// clear walk, one counter index per cycle
	// ----------------------------------------
	always_ff @(posedge i_ref_clk) begin
		if (!i_resetn) begin
			state_q     <= SSCR_IDLE;
			idx_q       <= IDX_FIRST;
			clr_ports_q <= PORTS_NONE;
		end else begin
			unique case (state_q)
				SSCR_IDLE: begin
					if (clear_q) begin
						state_q     <= SSCR_CLEAR;
						idx_q       <= IDX_FIRST;
						clr_ports_q <= port_en_q;
					end
				end
				SSCR_CLEAR: begin
					if (clear_done) begin
						state_q <= SSCR_IDLE;
					end else begin
						idx_q <= idx_q + IDX_STEP;
					end
				end
			endcase
		end
	end

	// ----------------------------------------
	// edge and led register
	// ----------------------------------------
	always_ff @(posedge i_ref_clk) begin
		if (!i_resetn) begin
			ref_edge_q   <= RST_EDGE_LED[BIT_REF_EDGE];
			spi_edge_q   <= RST_EDGE_LED[BIT_SPI_EDGE];
			led_mode_q   <= RST_EDGE_LED[LED_MODE_HI:LED_MODE_LO];
			host_reference_clock_out_q <= RST_EDGE_LED[BIT_HOST_REFERENCE_CLOCK_OUT];
		end else if (wr_edge) begin
			ref_edge_q   <= i_wdata[BIT_REF_EDGE];
			spi_edge_q   <= i_wdata[BIT_SPI_EDGE];
			led_mode_q   <= i_wdata[LED_MODE_HI:LED_MODE_LO];
			host_reference_clock_out_q <= i_wdata[BIT_HOST_REFERENCE_CLOCK_OUT];
		end
	end

	// ----------------------------------------
	// hold output, one flop per port
	// ----------------------------------------
	// the freeze mask follows the enable field live, unlike the clear snapshot
	always_ff @(posedge i_ref_clk) begin
		if (!i_resetn) begin
			o_stats_hold <= PORTS_NONE;
		end else begin
			o_stats_hold <= hold_q ? port_en_q : PORTS_NONE;
		end
	end

	// ----------------------------------------
	// clear strobe outputs
	// ----------------------------------------
	always_ff @(posedge i_ref_clk) begin
		if (!i_resetn) begin
			o_stats_clear_port  <= PORTS_NONE;
			o_stats_clear_index <= IDX_FIRST;
			o_stats_clear_we    <= 1'b0;
		end else begin
			o_stats_clear_port  <= is_walking(state_q) ? clr_ports_q : PORTS_NONE;
			o_stats_clear_index <= idx_q;
			o_stats_clear_we    <= is_walking(state_q);
		end
	end

	// ----------------------------------------
	// edge select outputs
	// ----------------------------------------
	always_ff @(posedge i_ref_clk) begin
		if (!i_resetn) begin
			o_ref_clk_falling <= RST_EDGE_LED[BIT_REF_EDGE];
			o_spi_read_rising <= RST_EDGE_LED[BIT_SPI_EDGE];
		end else begin
			o_ref_clk_falling <= ref_edge_q;
			o_spi_read_rising <= spi_edge_q;
		end
	end

	// ----------------------------------------
	// read port; reserved bits read zero
	// ----------------------------------------
	always_ff @(posedge i_ref_clk) begin
		if (!i_resetn) begin
			o_rvalid <= 1'b0;
		end else begin
			o_rvalid <= i_rd_en;
		end
	end

	// data holds between reads so a slow master can take it late
	always_ff @(posedge i_ref_clk) begin
		if (!i_resetn) begin
			o_rdata <= 8'h00;
		end else if (i_rd_en) begin
			unique case (i_addr)
				ADDR_STATS_CTRL:  o_rdata <= stats_image(clear_q, hold_q,
					port_en_q);
				ADDR_FACT_TEST_A: o_rdata <= RST_FACT_TEST_A;
				ADDR_FACT_TEST_B: o_rdata <= RST_FACT_TEST_B;
				ADDR_EDGE_LED:    o_rdata <= edge_image(ref_edge_q, led_mode_q, host_reference_clock_out_q,
					spi_edge_q);
				default:          o_rdata <= 8'h00;
			endcase
		end
	end
endmodule

// ---- dv/sscr_cnt_model.sv ----
`timescale 1ns/100ps
// counter bank stand-in: counts zeroing strobes, keeps last port mask
module sscr_cnt_model (
	input  wire logic       i_ref_clk,
	input  wire logic       i_resetn,
	input  wire logic       i_we,
	input  wire logic [4:0] i_port,
	output logic      [7:0] o_n,
	output logic      [4:0] o_port
);
	always_ff @(posedge i_ref_clk) begin
		if (!i_resetn) begin
			o_n <= 8'h00;
			o_port <= 5'h00;
		end else if (i_we) begin
			o_n <= o_n + 8'h01;
			o_port <= i_port;
		end
	end
endmodule

// ---- dv/sscr_regs_chk.sv ----
`timescale 1ns/100ps
module sscr_regs_chk (
	input wire logic       i_ref_clk, i_resetn, i_wr_en, i_rd_en,
	input wire logic [7:0] i_addr, i_wdata, o_rdata,
	input wire logic       o_rvalid, o_stats_clear_we, o_ref_clk_falling, o_spi_read_rising,
	input wire logic [4:0] o_stats_hold, o_stats_clear_port,
	input wire logic [5:0] o_stats_clear_index
);
	import sscr_pkg::*;
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_resetn);
	logic [7:0] s_q, e_q;
	wire w8 = i_wr_en && i_addr == ADDR_STATS_CTRL;
	wire wb = i_wr_en && i_addr == ADDR_EDGE_LED;
	// shadow copies so settled outputs can be tied to the last write
	always_ff @(posedge i_ref_clk) begin
		if (w8) s_q <= i_wdata;
		if (wb) e_q <= i_wdata;
	end
	sequence walk_s; o_stats_clear_we [*8]; endsequence
	sequence quiet_s; !i_wr_en [*2]; endsequence
	rd_valid_a: assert property (i_rd_en |=> o_rvalid) else $error("no read valid");
	rd_fact_a: assert property (i_rd_en && i_addr == ADDR_FACT_TEST_A
		|=> o_rdata == RST_FACT_TEST_A) else $error("bad fixed value");
	rd_unmap_a: assert property (i_rd_en && (i_addr < 8'h08 || i_addr > 8'h0B)
		|=> o_rdata == 8'h00) else $error("unmapped read not zero");
	hold_map_a: assert property (w8 ##1 quiet_s |=>
		o_stats_hold == ({5{s_q[6]}} & s_q[4:0])) else $error("hold mask wrong");
	ref_edge_a: assert property (wb ##1 quiet_s |=>
		o_ref_clk_falling == e_q[6]) else $error("ref edge wrong");
	spi_edge_a: assert property (wb ##1 quiet_s |=>
		o_spi_read_rising == e_q[0]) else $error("spi edge wrong");
	clr_start_a: assert property (w8 && i_wdata[7] && !o_stats_clear_we |->
		##[1:4] (o_stats_clear_we && o_stats_clear_index == 6'h00
		&& o_stats_clear_port == s_q[4:0]) ##1 walk_s) else $error("clear start wrong");
	idx_step_a: assert property (o_stats_clear_we && $past(o_stats_clear_we) |->
		o_stats_clear_index == $past(o_stats_clear_index) + 6'h01) else $error("index skip");
	clr_end_a: assert property ($fell(o_stats_clear_we) |->
		$past(o_stats_clear_index) == CLR_LAST) else $error("walk length wrong");
endmodule
bind sscr_regs sscr_regs_chk i_sscr_regs_chk (.*);

// ---- dv/sscr_regs_tb.sv ----
`timescale 1ns/100ps
module sscr_regs_tb;
	import sscr_pkg::*;
	logic       i_ref_clk = 1'b0, i_resetn = 1'b0, i_wr_en = 1'b0, i_rd_en = 1'b0;
	logic [7:0] i_addr = 8'h00, i_wdata = 8'h00, o_rdata, d, n;
	logic       o_rvalid, o_stats_clear_we, o_ref_clk_falling, o_spi_read_rising;
	logic [4:0] o_stats_hold, o_stats_clear_port, mp;
	logic [5:0] o_stats_clear_index;
	int         failures = 0, num_checks = 0, k;
	// rows: address, write data, read-back, hold mask
	logic [31:0] rows [7] = '{32'h086F4F0F, 32'h0BFF730F, 32'h0900400F, 32'h0AFF000F,
		32'h20AA000F, 32'h0B41410F, 32'h08000000};
	sscr_regs i_sscr_regs (.*);
	sscr_cnt_model i_sscr_cnt_model (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn),
		.i_we(o_stats_clear_we), .i_port(o_stats_clear_port), .o_n(n), .o_port(mp));
	always #4 i_ref_clk = ~i_ref_clk;
	task wr(input logic [7:0] a, v);
		@(negedge i_ref_clk);
		i_addr = a;
		i_wdata = v;
		i_wr_en = 1'b1;
		@(negedge i_ref_clk);
		i_wr_en = 1'b0;
	endtask
	task rd(input logic [7:0] a);
		@(negedge i_ref_clk);
		i_addr = a;
		i_rd_en = 1'b1;
		@(negedge i_ref_clk);
		i_rd_en = 1'b0;
		d = o_rdata;
	endtask
	task cmp(input string nm, input logic [7:0] e, g);
		num_checks++;
		if (g !== e) begin
			failures++;
			$display("wrong value %s exp %h got %h", nm, e, g);
		end
	endtask
	task tally_and_finish;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	initial begin
		repeat (20) @(negedge i_ref_clk);
		i_resetn = 1'b1;
		for (k = 0; k < 4; k++) begin
			rd(ADDR_STATS_CTRL + 8'(k));
			cmp("reset", k == 1 ? RST_FACT_TEST_A : 8'h00, d);
		end
		$display("reset test done");
		foreach (rows[j]) begin
			wr(rows[j][31:24], rows[j][23:16]);
			rd(rows[j][31:24]);
			@(negedge i_ref_clk);
			cmp("rdata", rows[j][15:8], d);
			cmp("hold", rows[j][7:0], {3'h0, o_stats_hold});
		end
		cmp("edges", 8'h03, {6'h00, o_ref_clk_falling, o_spi_read_rising});
		$display("table test done");
		// clear ports 1 and 3 while 2, 4, 5 stay out
		wr(ADDR_STATS_CTRL, 8'h85);
		for (k = 0; k < 100; k++) begin
			rd(ADDR_STATS_CTRL);
			if (d[7] === 1'b0) break;
		end
		if (k == 100) begin
			failures++;
		end else begin
			cmp("clr_rd", 8'h05, d);
			cmp("clr_n", 8'h24, n);
			cmp("clr_port", 8'h05, {3'h0, mp});
		end
		$display("clear test done");
		tally_and_finish;
	end
endmodule
